// file: rtl/sbt_pkg.sv
// Shared constants and types of the boundary-scan test port.
package sbt_pkg;

  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_LEN_DEF = 109;
  localparam int OE_CELL = 108;
  localparam int TMS_RESET_EDGES = 5;

  localparam logic [IR_W-1:0] IR_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] IR_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] IR_RSVD_A = 3'h3;
  localparam logic [IR_W-1:0] IR_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] IR_RSVD_B = 3'h5;
  localparam logic [IR_W-1:0] IR_RSVD_C = 3'h6;
  localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;

  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h1;
  localparam logic [IR_W-1:0] IR_RESET_VAL = IR_IDCODE;
  localparam logic BYPASS_CAPTURE_VAL = 1'b0;
  localparam logic OE_CELL_RESET_VAL = 1'b1;
  localparam logic TDO_RESET_VAL = 1'b0;
  localparam logic TDO_OE_N_RESET_VAL = 1'b1;

  typedef enum logic [3:0] {
    ST_TLR = 4'h0,
    ST_RTI = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SH_DR = 4'h4,
    ST_EX1_DR = 4'h5,
    ST_PAU_DR = 4'h6,
    ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'ha,
    ST_SH_IR = 4'hb,
    ST_EX1_IR = 4'hc,
    ST_PAU_IR = 4'hd,
    ST_EX2_IR = 4'he,
    ST_UPD_IR = 4'hf
  } sbt_state_t;

  typedef enum logic [1:0] {
    SEL_BYP = 2'h0,
    SEL_ID = 2'h1,
    SEL_BSR = 2'h2
  } sbt_sel_t;

endpackage

// file: rtl/sbt_sync.sv
// Two-flop level synchroniser of parameterised width.
`timescale 1ns/100ps
`default_nettype none
module sbt_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_q;

  if (W < 1) begin : g_w_chk
    $error("W must be at least one");
  end

  // The first stage feeds only the second, so no logic sees a metastable bit.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= RST_VAL;
      o_q <= RST_VAL;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end

endmodule
`default_nettype wire

// file: rtl/sbt_bsr.sv
// Boundary scan register: capture, shift and update stages.
`timescale 1ns/100ps
`default_nettype none
module sbt_bsr
  import sbt_pkg::*;
#(
  parameter int LEN = BSR_LEN_DEF
) (
  input wire logic i_tck,
  input wire logic i_nrst,
  input wire logic i_tlr,
  input wire logic i_capture,
  input wire logic i_shift,
  input wire logic i_update,
  input wire logic i_tdi,
  input wire logic [LEN-1:0] i_par,
  output logic o_sout,
  output logic [LEN-1:0] o_upd
);

  localparam logic [LEN-1:0] UPD_RST =
    {{(LEN-1){1'b0}}, OE_CELL_RESET_VAL} << OE_CELL;

  logic [LEN-1:0] sh_q;

  if (LEN <= OE_CELL) begin : g_len_chk
    $error("LEN must exceed the output-control cell index");
  end

  always_ff @(posedge i_tck or negedge i_nrst) begin
    if (!i_nrst) begin
      sh_q <= '0;
    end else if (i_capture) begin
      sh_q <= i_par;
    end else if (i_shift) begin
      sh_q <= {i_tdi, sh_q[LEN-1:1]};
    end
  end

  // The output-control cell returns to its preset whenever the port resets.
  always_ff @(posedge i_tck or negedge i_nrst) begin
    if (!i_nrst) begin
      o_upd <= UPD_RST;
    end else if (i_tlr) begin
      o_upd <= UPD_RST;
    end else if (i_update) begin
      o_upd <= sh_q;
    end
  end

  assign o_sout = sh_q[0];

endmodule
`default_nettype wire

// file: rtl/sbt_tap.sv
// Test access port controller with instruction and data scan registers.
`timescale 1ns/100ps
`default_nettype none
module sbt_tap
  import sbt_pkg::*;
#(
  parameter int BSR_LEN = sbt_pkg::BSR_LEN_DEF,
  // Arbitrary identification value; bit zero is one as the scheme demands.
  parameter logic [sbt_pkg::ID_W-1:0] ID_VALUE = 32'h5a5a_0001
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe_n,
  input wire logic [BSR_LEN-1:0] i_bnd_pins,
  output logic [BSR_LEN-1:0] o_bnd_drive,
  output logic o_extest,
  output logic o_q_oe
);

  import sbt_pkg::*;

  if (BSR_LEN <= OE_CELL) begin : g_len_chk
    $error("BSR_LEN must exceed the output-control cell index");
  end

  function automatic sbt_state_t tap_next(input sbt_state_t s,
                                          input logic tms);
    sbt_state_t n;
    n = ST_TLR;
    case (s)
      ST_TLR: n = tms ? ST_TLR : ST_RTI;
      ST_RTI: n = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: n = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: n = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: n = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: n = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: n = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: n = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: n = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: n = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: n = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: n = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: n = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: n = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: n = tms ? ST_SEL_DR : ST_RTI;
      default: n = ST_TLR;
    endcase
    return n;
  endfunction

  // Reserved codes fall back to bypass so the path never opens.
  function automatic sbt_sel_t sel_of(input logic [IR_W-1:0] ir);
    sbt_sel_t r;
    r = SEL_BYP;
    case (ir)
      IR_IDCODE: r = SEL_ID;
      IR_EXTEST: r = SEL_BSR;
      IR_SAMPLE_Z: r = SEL_BSR;
      IR_SAMPLE: r = SEL_BSR;
      default: r = SEL_BYP;
    endcase
    return r;
  endfunction

  sbt_state_t st_q;
  logic [IR_W-1:0] ir_sh_q;
  logic [IR_W-1:0] ir_q;
  logic byp_q;
  logic [ID_W-1:0] id_q;
  logic [BSR_LEN-1:0] pins_s;
  logic bsr_sout;
  logic [BSR_LEN-1:0] bsr_upd;
  logic q_oe_tck_q;
  logic extest_tck_q;
  logic dr_lsb;
  sbt_sel_t sel;
  logic cap_dr;
  logic sh_dr;
  logic upd_dr;
  logic in_tlr;
  logic [1:0] core_s;

  assign sel = sel_of(ir_q);
  assign cap_dr = (st_q == ST_CAP_DR);
  assign sh_dr = (st_q == ST_SH_DR);
  assign upd_dr = (st_q == ST_UPD_DR);
  assign in_tlr = (st_q == ST_TLR);

  // Power-up reset is asynchronous; the pads supply the pull-ups on mode
  // select and data input, so a floating pin walks the machine into reset.
  always_ff @(posedge i_tck or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= ST_TLR;
    end else begin
      st_q <= tap_next(st_q, i_tms);
    end
  end

  always_ff @(posedge i_tck or negedge i_nrst) begin
    if (!i_nrst) begin
      ir_sh_q <= IR_CAPTURE_VAL;
    end else if (st_q == ST_CAP_IR) begin
      ir_sh_q <= IR_CAPTURE_VAL;
    end else if (st_q == ST_SH_IR) begin
      ir_sh_q <= {i_tdi, ir_sh_q[IR_W-1:1]};
    end
  end

  always_ff @(posedge i_tck or negedge i_nrst) begin
    if (!i_nrst) begin
      ir_q <= IR_RESET_VAL;
    end else if (in_tlr) begin
      ir_q <= IR_RESET_VAL;
    end else if (st_q == ST_UPD_IR) begin
      ir_q <= ir_sh_q;
    end
  end

  always_ff @(posedge i_tck or negedge i_nrst) begin
    if (!i_nrst) begin
      byp_q <= BYPASS_CAPTURE_VAL;
    end else if (cap_dr && sel == SEL_BYP) begin
      byp_q <= BYPASS_CAPTURE_VAL;
    end else if (sh_dr && sel == SEL_BYP) begin
      byp_q <= i_tdi;
    end
  end

  always_ff @(posedge i_tck or negedge i_nrst) begin
    if (!i_nrst) begin
      id_q <= '0;
    end else if (cap_dr && sel == SEL_ID) begin
      id_q <= ID_VALUE;
    end else if (sh_dr && sel == SEL_ID) begin
      id_q <= {i_tdi, id_q[ID_W-1:1]};
    end
  end

  // Pin values come from the fast memory clock; they are synchronised so
  // that a capture never samples a half-settled level.
  sbt_sync #(
    .W(BSR_LEN),
    .RST_VAL('0)
  ) u_pin_sync (
    .i_clk(i_tck),
    .i_nrst(i_nrst),
    .i_d(i_bnd_pins),
    .o_q(pins_s)
  );

  sbt_bsr #(
    .LEN(BSR_LEN)
  ) u_bsr (
    .i_tck(i_tck),
    .i_nrst(i_nrst),
    .i_tlr(in_tlr),
    .i_capture(cap_dr && sel == SEL_BSR),
    .i_shift(sh_dr && sel == SEL_BSR),
    .i_update(upd_dr && sel == SEL_BSR),
    .i_tdi(i_tdi),
    .i_par(pins_s),
    .o_sout(bsr_sout),
    .o_upd(bsr_upd)
  );

  assign o_bnd_drive = bsr_upd;

  always_comb begin
    case (sel)
      SEL_ID: dr_lsb = id_q[0];
      SEL_BSR: dr_lsb = bsr_sout;
      default: dr_lsb = byp_q;
    endcase
  end

  // The falling-edge stage gives the far end half a period of setup.
  always_ff @(negedge i_tck or negedge i_nrst) begin
    if (!i_nrst) begin
      o_tdo <= TDO_RESET_VAL;
      o_tdo_oe_n <= TDO_OE_N_RESET_VAL;
    end else begin
      o_tdo_oe_n <= !(st_q == ST_SH_IR || sh_dr);
      if (st_q == ST_SH_IR) begin
        o_tdo <= ir_sh_q[0];
      end else if (sh_dr) begin
        o_tdo <= dr_lsb;
      end
    end
  end

  // Read-bus control is decided on the falling test-clock edge. The board
  // may stop the clock low right after an update, and this stage still
  // hands over the new instruction and cell value.
  always_ff @(negedge i_tck or negedge i_nrst) begin
    if (!i_nrst) begin
      q_oe_tck_q <= 1'b1;
      extest_tck_q <= 1'b0;
    end else begin
      extest_tck_q <= (ir_q == IR_EXTEST);
      if (ir_q == IR_SAMPLE_Z) begin
        q_oe_tck_q <= 1'b0;
      end else if (ir_q == IR_EXTEST) begin
        q_oe_tck_q <= bsr_upd[OE_CELL];
      end else begin
        q_oe_tck_q <= 1'b1;
      end
    end
  end

  // The core only ever sees these two levels on its own clock, so a port
  // reset or a stopped test clock cannot upset memory traffic.
  sbt_sync #(
    .W(2),
    .RST_VAL(2'h1)
  ) u_core_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d({extest_tck_q, q_oe_tck_q}),
    .o_q(core_s)
  );

  assign o_extest = core_s[1];
  assign o_q_oe = core_s[0];

  default clocking cb @(posedge i_tck);
  endclocking
  default disable iff (!i_nrst);

  a_tms_five_reset: assert property (
    i_tms [*5] |-> ##1 (st_q == ST_TLR)
  ) else $error("five high mode selects did not reach reset");

  a_ir_capture_val: assert property (
    (st_q == ST_CAP_IR) |=> (ir_sh_q[1:0] == 2'b01)
  ) else $error("instruction capture did not load 01");

  a_ir_reset_id: assert property (
    in_tlr |=> (ir_q == IR_IDCODE)
  ) else $error("instruction not identification after reset");

  a_ir_update_only: assert property (
    (st_q != ST_UPD_IR && !in_tlr) |=> $stable(ir_q)
  ) else $error("instruction changed outside update");

  a_byp_capture_low: assert property (
    (cap_dr && sel == SEL_BYP) |=> (byp_q == 1'b0)
  ) else $error("bypass did not capture low");

  a_id_capture_code: assert property (
    (cap_dr && sel == SEL_ID) |=> (id_q == ID_VALUE)
  ) else $error("identification code not captured");

  a_id_shift_msb: assert property (
    (sh_dr && sel == SEL_ID) |=> (id_q[ID_W-1] == $past(i_tdi))
  ) else $error("data input did not enter the top bit");

  a_tdo_float_idle: assert property (
    o_tdo_oe_n == !(st_q == ST_SH_IR || st_q == ST_SH_DR)
  ) else $error("data output enable does not follow shift states");

  a_tdo_ir_lsb: assert property (
    (st_q == ST_SH_IR) |-> (o_tdo == ir_sh_q[0])
  ) else $error("data output not instruction low bit");

  a_samplez_float: assert property (
    (ir_q == IR_SAMPLE_Z && st_q != ST_UPD_IR && !in_tlr) |=> !q_oe_tck_q
  ) else $error("read bus not floated under sample-z");

  c_ir_update: cover property (st_q == ST_UPD_IR);
  c_id_shift: cover property (sh_dr && sel == SEL_ID);
  c_tms_reset: cover property (i_tms [*5]);
  c_extest_float: cover property (ir_q == IR_EXTEST && !q_oe_tck_q);

endmodule
`default_nettype wire

// file: tb/sbt_jtag_ctl.sv
// Board-side scan controller model that drives the test port.
`timescale 1ns/100ps
`default_nettype none
module sbt_jtag_ctl (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo,
  input wire logic i_tdo_oe_n
);
  logic last_q;
  logic d;
  // The clock idles low between frames, so the port is never clocked idle.
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
    last_q = 1'b0;
  end
  // A released output has no pull, so it reads as its last level inverted.
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    o_tms <= tms;
    o_tdi <= tdi;
    #62.5;
    tdo = i_tdo_oe_n ? ~last_q : i_tdo;
    last_q = tdo;
    o_tck <= 1'b1;
    #62.5;
    o_tck <= 1'b0;
  endtask
  task automatic tap_reset();
    repeat (5) tick(1'b1, 1'b1, d);
  endtask
  task automatic shift_ir(input logic [2:0] code, output logic [2:0] cap);
    tick(1'b1, 1'b1, d);
    tick(1'b1, 1'b1, d);
    tick(1'b0, 1'b1, d);
    tick(1'b0, 1'b1, d);
    for (int i = 0; i < 3; i++) begin
      tick(i == 2, code[i], cap[i]);
    end
    tick(1'b1, 1'b1, d);
    tick(1'b0, 1'b1, d);
  endtask
  task automatic shift_dr(input int n, input logic [127:0] din,
                          output logic [127:0] dout);
    dout = '0;
    tick(1'b1, 1'b1, d);
    tick(1'b0, 1'b1, d);
    tick(1'b0, 1'b1, d);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], dout[i]);
    end
    tick(1'b1, 1'b1, d);
    tick(1'b0, 1'b1, d);
  endtask
endmodule
`default_nettype wire

// file: tb/tb_sbt_tap.sv
// Self-checking bench of the boundary-scan test port.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_sbt_tap;
  import sbt_pkg::*;
  localparam int L = 109;
  // Arbitrary identification value.
  localparam logic [ID_W-1:0] ID = 32'h5a5a_0001;
  localparam logic [L-1:0] DRV_RST = {1'b1, {(L-1){1'b0}}};
  localparam logic [L-1:0] PAT = {1'b0, {9{12'h5a6}}};
  // Starting high lets the first reset edge reach every process at time 0.
  logic i_nrst = 1'b1;
  logic i_clk, tck, tms, tdi, tdo, tdo_oe_n, extest, q_oe;
  logic [L-1:0] pins, drive;
  logic [127:0] q;
  logic [2:0] cap;
  logic d;
  int error_cnt, n_compared;
  sbt_tap #(.BSR_LEN(L), .ID_VALUE(ID)) sbt_tap_i (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n), .i_bnd_pins(pins),
    .o_bnd_drive(drive), .o_extest(extest), .o_q_oe(q_oe));
  sbt_jtag_ctl sbt_jtag_ctl_i (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
    .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n));
  always #25 i_clk = ~i_clk;
  task automatic close_out();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wait_clk();
    repeat (4) @(posedge i_clk);
  endtask
  task automatic t_power_up();
    `CHK(tdo_oe_n, 1'b1)
    `CHK(extest, 1'b0)
    `CHK(q_oe, 1'b1)
    `CHK(drive, DRV_RST)
  endtask
  task automatic t_idcode();
    sbt_jtag_ctl_i.tick(1'b0, 1'b1, d);
    sbt_jtag_ctl_i.shift_dr(ID_W, '0, q);
    `CHK(q[ID_W-1:0], ID)
    `CHK(tdo_oe_n, 1'b1)
  endtask
  task automatic t_bypass();
    logic [2:0] codes [4];
    codes = '{IR_BYPASS, IR_RSVD_A, IR_RSVD_B, IR_RSVD_C};
    foreach (codes[k]) begin
      sbt_jtag_ctl_i.shift_ir(codes[k], cap);
      `CHK(cap, IR_CAPTURE_VAL)
      sbt_jtag_ctl_i.shift_dr(8, 128'hb5, q);
      `CHK(q[7:0], 8'h6a)
    end
  endtask
  task automatic t_preload_extest();
    sbt_jtag_ctl_i.shift_ir(IR_SAMPLE, cap);
    sbt_jtag_ctl_i.shift_dr(L, {19'h0, PAT}, q);
    `CHK(q[L-1:0], pins)
    `CHK(drive, PAT)
    wait_clk();
    `CHK(q_oe, 1'b1)
    sbt_jtag_ctl_i.shift_ir(IR_EXTEST, cap);
    wait_clk();
    `CHK(extest, 1'b1)
    `CHK(q_oe, 1'b0)
    sbt_jtag_ctl_i.shift_dr(L, {19'h0, ~PAT}, q);
    `CHK(q[L-1:0], pins)
    wait_clk();
    `CHK(q_oe, 1'b1)
  endtask
  task automatic t_sample_z_reset();
    sbt_jtag_ctl_i.shift_ir(IR_SAMPLE_Z, cap);
    wait_clk();
    `CHK(q_oe, 1'b0)
    `CHK(extest, 1'b0)
    sbt_jtag_ctl_i.tick(1'b1, 1'b1, d);
    sbt_jtag_ctl_i.tick(1'b0, 1'b1, d);
    sbt_jtag_ctl_i.tap_reset();
    sbt_jtag_ctl_i.tick(1'b0, 1'b1, d);
    wait_clk();
    `CHK(q_oe, 1'b1)
    `CHK(drive, DRV_RST)
    sbt_jtag_ctl_i.shift_dr(ID_W, '0, q);
    `CHK(q[ID_W-1:0], ID)
  endtask
  initial begin
    #500_000;
    error_cnt++;
    close_out();
  end
  initial begin
    i_clk = 1'b0;
    i_nrst <= 1'b0;
    error_cnt = 0;
    n_compared = 0;
    pins <= {1'b1, {9{12'h9c3}}};
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    // Offset keeps the test clock out of step with the memory clock.
    #7;
    t_power_up();
    t_idcode();
    t_bypass();
    t_preload_extest();
    t_sample_z_reset();
    close_out();
  end
endmodule
`default_nettype wire
